// >>> logic/sdr_bank_access.sv
// Purpose: device side command and data interface of a four-bank sdram
// Assumes: every pin passes two flip-flops before decode; wide variant
// Notes:   read data leaves three edges after the command edge
//
// Behaviour
// [RQ1] four banks, 4096 rows, 512 columns of 16 bits each
// [RQ2] all command, address and data inputs captured on rising clock edge
// [RQ3] row activation first; column command only to an open bank
// [RQ4] activation: bank selects pick bank, twelve address bits pick row
// [RQ5] column command: nine address bits give the starting column
// [RQ6] burst runs programmed length in programmed sequential or interleaved order
// [RQ7] lengths 1, 2, 4, 8, full page; terminate command ends burst
// [RQ8] column addresses generated internally; new column command any cycle
// [RQ9] auto precharge closes the row by itself after the burst
// [RQ10] one bank may precharge while another bank is accessed
// [RQ11] separate low and high byte masks, one per byte lane
// [RQ12] chip select high ignores commands and holds state; the code still advances a running burst and precharge counts
// [RQ13] mask high blocks a written byte, floats a read byte
// [RQ14] precharge bit high closes all banks, low only selected bank
// [RQ15] controller precharges before activating another row in a bank
`timescale 1ns/1ps
`default_nettype none

module sdr_bank_access
  import sdr_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 clockEnable,
  input  wire logic                 chipSelectN,
  input  wire logic                 rowStrobeN,
  input  wire logic                 colStrobeN,
  input  wire logic                 writeEnableN,
  input  wire logic                 bankSelectLsb,
  input  wire logic                 bankSelectMsb,
  input  wire logic [ROW_W-1:0]     rowColAddressBus,
  input  wire logic                 lowByteMask,
  input  wire logic                 highByteMask,
  input  wire logic [DQ_W-1:0]      dataBusIn,
  output var  logic [DQ_W-1:0]      dataBusOut,
  output var  logic [NUM_BYTES-1:0] dataBusOe
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    sdr_pins_t                            pin1;
    sdr_pins_t                            pin2;
    logic [2:0]                           burstCode;
    logic                                 interleave;
    logic [NUM_BANKS-1:0]                 bankOpen;
    logic [NUM_BANKS-1:0][ROW_W-1:0]      bankRow;
    logic [NUM_BANKS-1:0][PRE_CNT_W-1:0]  preCnt;
    sdr_burst_t                           burst;
    logic [BANK_W-1:0]                    burstBank;
    logic [COL_W-1:0]                     startCol;
    logic [COL_W-1:0]                     cnt;
    logic                                 autoPre;
    logic                                 rdValid;
    logic [NUM_BYTES-1:0]                 rdMask;
    logic [DQ_W-1:0]                      dqOut;
    logic [NUM_BYTES-1:0]                 dqOe;
  } sdr_state_t;

  sdr_state_t cur;
  sdr_state_t next_cur;
  sdr_pins_t  pins;

  logic                 memWe;
  logic [NUM_BYTES-1:0] memBe;
  logic [MEM_AW-1:0]    memAddr;
  logic [DQ_W-1:0]      memRd;

  assign pins = '{cke: clockEnable, csN: chipSelectN, rasN: rowStrobeN,
                  casN: colStrobeN, weN: writeEnableN,
                  ba: {bankSelectMsb, bankSelectLsb}, addr: rowColAddressBus,
                  lowMask: lowByteMask, highMask: highByteMask, dq: dataBusIn};

  assign dataBusOut = cur.dqOut;
  assign dataBusOe  = cur.dqOe;

  // ---------------------------------------------------------------
  // column generation
  // ---------------------------------------------------------------
  function automatic logic [COL_W-1:0] burstMask(input logic [2:0] code);
    logic [COL_W-1:0] m;
    m = COL_FULL;
    if (code <= BL_MAXCODE)
    begin
      m = (COL_ONE << code) - COL_ONE;
    end
    return m;
  endfunction

  function automatic logic [COL_W-1:0] burstCol(
    input logic [COL_W-1:0] start,
    input logic [COL_W-1:0] cnt,
    input logic [COL_W-1:0] mask,
    input logic             il
  );
    logic [COL_W-1:0] off;
    off = il ? (start ^ cnt) : COL_W'(start + cnt);
    return (start & ~mask) | (off & mask);
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    sdr_pins_t        p;
    logic [2:0]       cmd;
    logic [COL_W-1:0] mask;
    logic [COL_W-1:0] col;
    p        = cur.pin2;
    cmd      = {p.rasN, p.casN, p.weN};
    mask     = burstMask(cur.burstCode);
    col      = '0;
    next_cur = cur;
    memWe    = 1'b0;
    memBe    = '0;
    memAddr  = '0;

    next_cur.pin1    = pins; // RQ2
    next_cur.pin2    = cur.pin1;
    next_cur.rdValid = 1'b0;
    next_cur.dqOut   = memRd;
    next_cur.dqOe    = cur.rdValid ? ~cur.rdMask : '0; // RQ13

    if (p.cke)
    begin
      for (int b = 0; b < NUM_BANKS; b++)
      begin
        if (cur.preCnt[b] != '0)
        begin
          next_cur.preCnt[b] = cur.preCnt[b] - PRE_CNT_W'(1); // RQ10
        end
      end

      if (!p.csN) // RQ12
      begin
        case (cmd)
          CMD_MODE:
          begin
            if (cur.bankOpen == '0)
            begin
              next_cur.burstCode  = p.addr[MODE_BL_LSB +: 3];
              next_cur.interleave = p.addr[MODE_IL_BIT];
            end
          end
          CMD_ACTIVE:
          begin
            // a bank already open keeps its row until precharged
            if (!cur.bankOpen[p.ba] && cur.preCnt[p.ba] == '0) // RQ15
            begin
              next_cur.bankOpen[p.ba] = 1'b1; // RQ4
              next_cur.bankRow[p.ba]  = p.addr;
            end
          end
          CMD_READ, CMD_WRITE:
          begin
            if (cur.bankOpen[p.ba]) // RQ3
            begin
              next_cur.burst     = (cmd == CMD_READ) ? SDR_READ : SDR_WRITE; // RQ8
              next_cur.burstBank = p.ba;
              next_cur.startCol  = p.addr[COL_W-1:0]; // RQ5
              next_cur.cnt       = '0;
              next_cur.autoPre   = p.addr[PRECHARGE_ALL_SELECT_BIT];
            end
          end
          CMD_TERM:
          begin
            next_cur.burst = SDR_IDLE; // RQ7
          end
          CMD_PRECHARGE:
          begin
            for (int b = 0; b < NUM_BANKS; b++)
            begin
              if ((p.addr[PRECHARGE_ALL_SELECT_BIT] || p.ba == BANK_W'(b))
                  && cur.bankOpen[b]) // RQ14
              begin
                next_cur.bankOpen[b] = 1'b0;
                next_cur.preCnt[b]   = PRE_CYC;
                if (cur.burst != SDR_IDLE && cur.burstBank == BANK_W'(b))
                begin
                  next_cur.burst = SDR_IDLE;
                end
              end
            end
          end
          default:
          begin
            next_cur.burst = next_cur.burst;
          end
        endcase
      end

      if (next_cur.burst != SDR_IDLE)
      begin
        col     = burstCol(next_cur.startCol, next_cur.cnt, mask,
                           cur.interleave); // RQ6
        memAddr = {next_cur.burstBank, cur.bankRow[next_cur.burstBank], col}; // RQ1
        if (next_cur.burst == SDR_WRITE)
        begin
          memWe = 1'b1;
          memBe = ~{p.highMask, p.lowMask}; // RQ11
        end
        else
        begin
          next_cur.rdValid = 1'b1;
          next_cur.rdMask  = {p.highMask, p.lowMask};
        end
        if (cur.burstCode <= BL_MAXCODE && next_cur.cnt == mask)
        begin
          next_cur.burst = SDR_IDLE;
          if (next_cur.autoPre) // RQ9
          begin
            next_cur.bankOpen[next_cur.burstBank] = 1'b0;
            next_cur.preCnt[next_cur.burstBank]   = PRE_CYC;
          end
        end
        else
        begin
          next_cur.cnt = next_cur.cnt + COL_ONE; // RQ8
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur           <= '0;
      cur.burstCode <= MODE_BL_RESET;
      cur.burst     <= SDR_IDLE;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  sdr_mem_array u_mem (
    .clk    (clk),
    .wrEn   (memWe),
    .byteEn (memBe),
    .addr   (memAddr),
    .wrData (cur.pin2.dq),
    .rdData (memRd)
  );

endmodule

`default_nettype wire

// >>> logic/sdr_mem_array.sv
// Purpose: storage of all four banks, byte-masked write, registered read
// Assumes: address is {bank, row, column}
// Notes:   read data appears one edge after the address
`timescale 1ns/1ps
`default_nettype none

module sdr_mem_array
  import sdr_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 wrEn,
  input  wire logic [NUM_BYTES-1:0] byteEn,
  input  wire logic [MEM_AW-1:0]    addr,
  input  wire logic [DQ_W-1:0]      wrData,
  output var  logic [DQ_W-1:0]      rdData
);

  logic [DQ_W-1:0] mem [0:MEM_DEPTH-1];

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < NUM_BYTES; i++)
    begin
      if (wrEn && byteEn[i])
      begin
        mem[addr][i*8 +: 8] <= wrData[i*8 +: 8];
      end
    end
    rdData <= mem[addr];
  end

endmodule

`default_nettype wire

// >>> logic/sdr_pkg.sv
// Purpose: shared constants and types of the sdram bank access block
// Assumes: wide (16-bit) data variant, 100 MHz clock
// Notes:   command codes are {rowStrobeN, colStrobeN, writeEnableN}
`default_nettype none

package sdr_pkg;

  // ---------------------------------------------------------------
  // array organisation
  // ---------------------------------------------------------------
  localparam int NUM_BANKS = 4;
  localparam int BANK_W    = 2;
  localparam int ROW_W     = 12;
  localparam int NUM_ROWS  = 4096;
  localparam int COL_W     = 9;
  localparam int NUM_COLS  = 512;
  localparam int DQ_W      = 16;
  localparam int NUM_BYTES = 2;
  localparam int MEM_AW    = BANK_W + ROW_W + COL_W;
  localparam int MEM_DEPTH = NUM_BANKS * NUM_ROWS * NUM_COLS;

  // ---------------------------------------------------------------
  // commands and address fields
  // ---------------------------------------------------------------
  localparam logic [2:0] CMD_MODE      = 3'h0;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_ACTIVE    = 3'h3;
  localparam logic [2:0] CMD_WRITE     = 3'h4;
  localparam logic [2:0] CMD_READ      = 3'h5;
  localparam logic [2:0] CMD_TERM      = 3'h6;
  localparam int PRECHARGE_ALL_SELECT_BIT = 10;

  // mode word: burst length code in [2:0], interleaved order in [3]
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_IL_BIT = 3;
  localparam logic [2:0] BL_FULL    = 3'h7;
  localparam logic [2:0] BL_MAXCODE = 3'h3;
  localparam logic [2:0] MODE_BL_RESET = 3'h0;
  localparam logic [COL_W-1:0] COL_ONE  = 9'h001;
  localparam logic [COL_W-1:0] COL_FULL = 9'h1ff;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int PRE_TIME_NS   = 20;
  localparam int PRE_CNT_W     = 2;
  localparam logic [PRE_CNT_W-1:0] PRE_CYC =
    PRE_CNT_W'((PRE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SDR_IDLE  = 2'b00,
    SDR_READ  = 2'b01,
    SDR_WRITE = 2'b11
  } sdr_burst_t;

  typedef struct packed {
    logic              cke;
    logic              csN;
    logic              rasN;
    logic              casN;
    logic              weN;
    logic [BANK_W-1:0] ba;
    logic [ROW_W-1:0]  addr;
    logic              lowMask;
    logic              highMask;
    logic [DQ_W-1:0]   dq;
  } sdr_pins_t;

endpackage

`default_nettype wire

// >>> tb/sdr_bank_access_assertions.sv
// Purpose: port checks of the sdram bank access block
// Assumes: read beat k leaves three edges after its sampling edge, sampled at the fourth
// Notes:   bound from the testbench top
`timescale 1ns/1ps
`default_nettype none

module sdr_bank_access_assertions
  import sdr_pkg::*;
(
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic             clockEnable,
  input wire logic             chipSelectN,
  input wire logic             rowStrobeN,
  input wire logic             colStrobeN,
  input wire logic             writeEnableN,
  input wire logic             bankSelectLsb,
  input wire logic             bankSelectMsb,
  input wire logic [ROW_W-1:0] rowColAddressBus,
  input wire logic             lowByteMask,
  input wire logic             highByteMask,
  input wire logic [1:0]       dataBusOe
);
  logic       go;
  logic [1:0] bank;
  assign go = !chipSelectN && clockEnable;
  assign bank = {bankSelectMsb, bankSelectLsb};

  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_cmd(c);
    go && {rowStrobeN, colStrobeN, writeEnableN} == c;
  endsequence
  sequence s_pre(allBit);
    s_cmd(CMD_PRECHARGE) ##0 rowColAddressBus[PRECHARGE_ALL_SELECT_BIT] == allBit;
  endsequence
  sequence s_readSame;
    s_cmd(CMD_READ) ##0 bank == $past(bank);
  endsequence

  property p_resetQuiet;
    $rose(rst_n) |-> (dataBusOe == 2'h0) [*5];
  endproperty
  property p_openRead;
    s_cmd(CMD_ACTIVE) ##1 (s_readSame ##0 !lowByteMask && !highByteMask)
      |-> ##4 dataBusOe == 2'h3;
  endproperty
  property p_writeQuiet;
    s_cmd(CMD_WRITE) |-> ##4 dataBusOe == 2'h0;
  endproperty
  property p_maskLanes;
    dataBusOe != 2'h0 |-> dataBusOe == ~{$past(highByteMask, 4), $past(lowByteMask, 4)};
  endproperty
  property p_csIgnore;
    (chipSelectN && dataBusOe == 2'h0) [*8] |=> dataBusOe == 2'h0;
  endproperty
  property p_termStops;
    s_cmd(CMD_TERM) |-> ##[1:6] dataBusOe == 2'h0;
  endproperty
  property p_preAll;
    s_pre(1'b1) ##1 s_cmd(CMD_READ) |-> ##4 dataBusOe == 2'h0;
  endproperty
  property p_preOne;
    s_pre(1'b0) ##1 s_readSame |-> ##4 dataBusOe == 2'h0;
  endproperty

  a_resetQuiet: assert property (p_resetQuiet)
    else $error("bus driven after reset");
  a_openRead: assert property (p_openRead)
    else $error("read of open bank not driven");
  a_writeQuiet: assert property (p_writeQuiet)
    else $error("bus driven during write");
  a_maskLanes: assert property (p_maskLanes)
    else $error("lane enable disagrees with mask");
  a_csIgnore: assert property (p_csIgnore)
    else $error("deselected command acted on");
  a_termStops: assert property (p_termStops)
    else $error("burst not terminated");
  a_preAll: assert property (p_preAll)
    else $error("read after precharge all driven");
  a_preOne: assert property (p_preOne)
    else $error("read after bank precharge driven");
endmodule

`default_nettype wire

// >>> tb/sdr_bank_access_test.sv
// Purpose: self-checking bench of the sdram bank access block
// Assumes: read beat k is seen at the fourth falling edge after its edge
// Notes:   the data wire is resolved per byte from the device's enables only
`timescale 1ns/1ps
`default_nettype none

module sdr_bank_access_test
  import sdr_pkg::*;
;
  localparam logic [3:0] NOP  = 4'hf;
  localparam logic [3:0] MODE = {1'b0, CMD_MODE};
  localparam logic [3:0] ACT  = {1'b0, CMD_ACTIVE};
  localparam logic [3:0] RD   = {1'b0, CMD_READ};
  localparam logic [3:0] WR   = {1'b0, CMD_WRITE};
  localparam logic [3:0] PRE  = {1'b0, CMD_PRECHARGE};
  logic             clk, rst_n, clockEnable, chipSelectN, rowStrobeN, colStrobeN;
  logic             writeEnableN, bankSelectLsb, bankSelectMsb, lowByteMask, highByteMask;
  logic [ROW_W-1:0] rowColAddressBus;
  logic [DQ_W-1:0]  ctrlData, dataBusIn, dataBusOut, got [12];
  logic [1:0]       dataBusOe, oe [12];
  int               fails, totalChecks;

  assign dataBusIn = {dataBusOe[1] ? dataBusOut[15:8] : ctrlData[15:8],
                      dataBusOe[0] ? dataBusOut[7:0] : ctrlData[7:0]};

  sdr_bank_access sdr_bank_access_inst (.clk, .rst_n, .clockEnable, .chipSelectN,
    .rowStrobeN, .colStrobeN, .writeEnableN, .bankSelectLsb, .bankSelectMsb,
    .rowColAddressBus, .lowByteMask, .highByteMask, .dataBusIn, .dataBusOut, .dataBusOe);
  sdr_ctrl_model sdr_ctrl_model_inst (.clk, .clockEnable, .chipSelectN, .rowStrobeN,
    .colStrobeN, .writeEnableN, .bankSelectLsb, .bankSelectMsb, .rowColAddressBus,
    .lowByteMask, .highByteMask, .ctrlData);

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic giveVerdict;
    if (fails == 0 && totalChecks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
    input logic [15:0] d);
    sdr_ctrl_model_inst.issue(c, b, a, d, 2'h0);
  endtask

  task automatic nop(input int n);
    repeat (n) cmd(NOP, 2'h0, 12'h000, ~ctrlData);
  endtask

  // issue one read, then collect beats 0..n
  task automatic rdBurst(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
    input int n, input logic [1:0] m);
    sdr_ctrl_model_inst.issue(c, b, a, 16'h0000, m);
    nop(3);
    for (int k = 0; k <= n; k++)
    begin
      nop(1);
      got[k] = dataBusOut;
      oe[k] = dataBusOe;
    end
  endtask

  task automatic expectOe(input int n, input logic [1:0] e);
    for (int k = 0; k < n; k++)
      check(oe[k], e);
  endtask

  task automatic burstOrder;
    cmd(MODE, 2'h0, 12'h002, 16'h0000);
    cmd(ACT, 2'h1, 12'h005, 16'h0000);
    for (int k = 0; k < 4; k++)
      cmd(k == 0 ? WR : NOP, 2'h1, 12'h006, 16'h1111 * 16'(k + 1));
    nop(2);
    cmd(RD, 2'h1, 12'h006, 16'h0000);
    rdBurst(RD, 2'h1, 12'h004, 4, 2'h0);
    for (int k = 0; k < 4; k++)
      check(got[k], 16'h1111 * 16'((k + 2) % 4 + 1));
    expectOe(4, 2'h3);
    check(oe[4], 2'h0);
  endtask

  task automatic maskAndIgnore;
    sdr_ctrl_model_inst.issue(WR, 2'h1, 12'h004, 16'h5533, 2'h2);
    sdr_ctrl_model_inst.issue(NOP, 2'h1, 12'h004, 16'h4455, 2'h1);
    nop(2);
    rdBurst(RD, 2'h1, 12'h004, 1, 2'h1);
    check(oe[0], 2'h2);
    check(got[0][15:8], 8'h33);
    check(got[0], 16'h3333);
    check(got[1], 16'h4444);
    nop(8);
    rdBurst({1'b1, CMD_READ}, 2'h1, 12'h004, 4, 2'h0);
    expectOe(5, 2'h0);
    cmd({1'b1, CMD_ACTIVE}, 2'h2, 12'h007, 16'h0000);
    rdBurst(RD, 2'h2, 12'h000, 4, 2'h0);
    expectOe(5, 2'h0);
  endtask

  task automatic precharging;
    cmd(ACT, 2'h2, 12'h007, 16'h0000);
    rdBurst(RD, 2'h1, 12'h404, 4, 2'h0);
    check(got[0], 16'h3333);
    rdBurst(RD, 2'h2, 12'h000, 4, 2'h0);
    expectOe(4, 2'h3);
    rdBurst(RD, 2'h1, 12'h004, 4, 2'h0);
    expectOe(5, 2'h0);
    cmd(PRE, 2'h0, 12'h400, 16'h0000);
    rdBurst(RD, 2'h2, 12'h000, 4, 2'h0);
    expectOe(5, 2'h0);
    cmd(ACT, 2'h1, 12'h005, 16'h0000);
    rdBurst(RD, 2'h1, 12'h004, 4, 2'h0);
    check(got[0], 16'h3333);
    cmd(ACT, 2'h2, 12'h007, 16'h0000);
    cmd(PRE, 2'h1, 12'h000, 16'h0000);
    rdBurst(RD, 2'h1, 12'h004, 4, 2'h0);
    expectOe(5, 2'h0);
    rdBurst(RD, 2'h2, 12'h000, 4, 2'h0);
    expectOe(4, 2'h3);
  endtask

  task automatic fullPage;
    cmd(PRE, 2'h0, 12'h400, 16'h0000);
    nop(3);
    cmd(MODE, 2'h0, 12'h00b, 16'h0000);
    cmd(ACT, 2'h1, 12'h005, 16'h0000);
    rdBurst(RD, 2'h1, 12'h005, 8, 2'h0);
    check(got[0], 16'h4444);
    check(got[1], 16'h3333);
    expectOe(8, 2'h3);
    check(oe[8], 2'h0);
    cmd(PRE, 2'h0, 12'h400, 16'h0000);
    cmd(MODE, 2'h0, 12'h007, 16'h0000);
    cmd(ACT, 2'h0, 12'h001, 16'h0000);
    rdBurst(RD, 2'h0, 12'h1fe, 10, 2'h0);
    expectOe(11, 2'h3);
    cmd({1'b0, CMD_TERM}, 2'h0, 12'h000, 16'h0000);
    nop(6);
    check(dataBusOe, 2'h0);
  endtask

  initial
  begin
    fails = 0;
    totalChecks = 0;
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    check(dataBusOe, 2'h0);
    check(dataBusOut, 16'h0000);
    burstOrder;
    maskAndIgnore;
    precharging;
    fullPage;
    giveVerdict;
  end
endmodule

bind sdr_bank_access sdr_bank_access_assertions sdr_bank_access_assertions_inst (
  .clk, .rst_n, .clockEnable, .chipSelectN, .rowStrobeN, .colStrobeN, .writeEnableN,
  .bankSelectLsb, .bankSelectMsb, .rowColAddressBus, .lowByteMask, .highByteMask,
  .dataBusOe);

`default_nettype wire

// >>> tb/sdr_ctrl_model.sv
// Purpose: memory controller model driving command and data pins
// Assumes: pins change only at the falling clock edge
// Notes:   the caller passes inverted data when the lines are released
`timescale 1ns/1ps
`default_nettype none

module sdr_ctrl_model
  import sdr_pkg::*;
(
  input  wire logic             clk,
  output var  logic             clockEnable,
  output var  logic             chipSelectN,
  output var  logic             rowStrobeN,
  output var  logic             colStrobeN,
  output var  logic             writeEnableN,
  output var  logic             bankSelectLsb,
  output var  logic             bankSelectMsb,
  output var  logic [ROW_W-1:0] rowColAddressBus,
  output var  logic             lowByteMask,
  output var  logic             highByteMask,
  output var  logic [DQ_W-1:0]  ctrlData
);
  initial
  begin
    clockEnable = 1'b1;
    {chipSelectN, rowStrobeN, colStrobeN, writeEnableN} = 4'hf;
    {bankSelectMsb, bankSelectLsb} = 2'h0;
    rowColAddressBus = 12'h000;
    {highByteMask, lowByteMask} = 2'h0;
    ctrlData = 16'h0000;
  end

  // one cycle of pins; deselected no-op cycles carry burst data
  task automatic issue(input logic [3:0] c, input logic [1:0] b,
    input logic [ROW_W-1:0] a, input logic [DQ_W-1:0] d, input logic [1:0] m);
    @(negedge clk);
    {chipSelectN, rowStrobeN, colStrobeN, writeEnableN} = c;
    {bankSelectMsb, bankSelectLsb} = b;
    rowColAddressBus = a;
    {highByteMask, lowByteMask} = m;
    ctrlData = d;
  endtask
endmodule

`default_nettype wire
